// file: logic/drive_ctrl_pkg.sv
package drive_ctrl_pkg;
   // -----------------------------------------------------------------
   // parameter selectors and values
   // -----------------------------------------------------------------
   localparam logic [1:0] SRC_PANEL = 2'h0;
   localparam logic [1:0] SRC_TERM = 2'h1;
   localparam logic [1:0] SRC_SERIAL = 2'h2;
   localparam logic [4:0] TERM_FN_FWD = 5'h06;
   localparam logic [4:0] TERM_FN_REV = 5'h07;
   localparam logic [4:0] TERM_FN_STOP = 5'h09;
   localparam logic [3:0] RESTORE_CODE = 4'h8;
   // -----------------------------------------------------------------
   // parameter ids for the write port
   // -----------------------------------------------------------------
   localparam logic [4:0] PID_SETPOINT = 5'h00;
   localparam logic [4:0] PID_RUN_SRC = 5'h02;
   localparam logic [4:0] PID_STOP_LOCK = 5'h03;
   localparam logic [4:0] PID_REV_PERMIT = 5'h04;
   localparam logic [4:0] PID_MAX_FREQ = 5'h05;
   localparam logic [4:0] PID_MIN_FREQ = 5'h06;
   localparam logic [4:0] PID_ACCEL = 5'h07;
   localparam logic [4:0] PID_DECEL = 5'h08;
   localparam logic [4:0] PID_VF_MAXV = 5'h09;
   localparam logic [4:0] PID_VF_BASEF = 5'h0a;
   localparam logic [4:0] PID_VF_MIDV = 5'h0b;
   localparam logic [4:0] PID_VF_MIDF = 5'h0c;
   localparam logic [4:0] PID_VF_MINV = 5'h0d;
   localparam logic [4:0] PID_VF_MINF = 5'h0e;
   localparam logic [4:0] PID_CARRIER = 5'h0f;
   localparam logic [4:0] PID_RESTORE = 5'h11;
   localparam logic [4:0] PID_WLOCK = 5'h12;
   localparam logic [4:0] PID_ACCEL2 = 5'h13;
   localparam logic [4:0] PID_DECEL2 = 5'h14;
   localparam logic [4:0] PID_TERM_A = 5'h15;
   localparam logic [4:0] PID_TERM_B = 5'h16;
   localparam logic [4:0] PID_TERM_C = 5'h17;
   // -----------------------------------------------------------------
   // factory values (freq/volt in 0.01 units, time in 0.1 s)
   // -----------------------------------------------------------------
   localparam logic [15:0] RST_SETPOINT = 16'h0000;
   localparam logic [1:0] RST_RUN_SRC = 2'h0;
   localparam logic RST_STOP_LOCK = 1'b1;
   localparam logic RST_REV_PERMIT = 1'b1;
   localparam logic [15:0] RST_MAX_FREQ = 16'h1388;
   localparam logic [15:0] FREQ_CEIL = 16'h9c40;
   localparam logic [15:0] RST_MIN_FREQ = 16'h0000;
   localparam logic [15:0] RST_ACCEL = 16'h0050;
   localparam logic [15:0] RST_DECEL = 16'h0050;
   localparam logic [15:0] TIME_MIN = 16'h0001;
   localparam logic [15:0] TIME_MAX = 16'h270f;
   localparam logic [15:0] RST_VF_MAXV = 16'h9470;
   localparam logic [15:0] VOLT_CEIL = 16'hc350;
   localparam logic [15:0] RST_VF_BASEF = 16'h1388;
   localparam logic [15:0] RST_VF_MIDV = 16'h0578;
   localparam logic [15:0] RST_VF_MIDF = 16'h00fa;
   localparam logic [15:0] RST_VF_MINV = 16'h05dc;
   localparam logic [15:0] RST_VF_MINF = 16'h007d;
   localparam logic [3:0] RST_CARRIER = 4'h5;
   localparam logic [3:0] CARRIER_MIN = 4'h1;
   localparam logic [3:0] CARRIER_MAX = 4'hf;
   localparam logic [4:0] RST_TERM_A = 5'h06;
   localparam logic [4:0] RST_TERM_B = 5'h07;
   localparam logic [4:0] RST_TERM_C = 5'h09;
   // -----------------------------------------------------------------
   // timing
   // -----------------------------------------------------------------
   localparam int CLK_HZ = 100_000_000;
   localparam int TICK_US = 100;
   localparam int TICK_CYC = CLK_HZ / 1_000_000 * TICK_US;
   localparam int HOLD_MS = 2000;
   localparam int HOLD_CYC = CLK_HZ / 1000 * HOLD_MS;
   localparam int DEBOUNCE_US = 1000;
   localparam int DEBOUNCE_CYC = CLK_HZ / 1_000_000 * DEBOUNCE_US;
   localparam int TICKS_PER_DS = 1000;

   typedef enum logic [2:0] {
      RUN_STOP = 3'b001,
      RUN_FWD = 3'b010,
      RUN_REV = 3'b100
   } run_state_t;
endpackage

// file: logic/input_filter.sv
module input_filter #(
   parameter int WIDTH = 8,
   parameter int STABLE_CYC = 100_000
) (
   // clock and reset
   input wire logic i_core_clk,
   input wire logic i_rstn,
   // raw pins
   input wire logic [WIDTH-1:0] i_raw,
   // clean level and edges
   output logic [WIDTH-1:0] o_level,
   output logic [WIDTH-1:0] o_rise,
   output logic [WIDTH-1:0] o_fall
);
   logic [WIDTH-1:0] meta_reg;
   logic [WIDTH-1:0] sync_reg;
   logic [WIDTH-1:0][31:0] cnt_reg;

   always_ff @(posedge i_core_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         meta_reg <= '0;
         sync_reg <= '0;
      end else begin
         meta_reg <= i_raw;
         sync_reg <= meta_reg;
      end
   end

   // level accepted after staying different for the stable time
   always_ff @(posedge i_core_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         cnt_reg <= '0;
         o_level <= '0;
         o_rise <= '0;
         o_fall <= '0;
      end else begin
         for (int i = 0; i < WIDTH; i++) begin
            o_rise[i] <= 1'b0;
            o_fall[i] <= 1'b0;
            if (sync_reg[i] == o_level[i]) begin
               cnt_reg[i] <= '0;
            end else if (cnt_reg[i] >= 32'(STABLE_CYC - 1)) begin
               cnt_reg[i] <= '0;
               o_level[i] <= sync_reg[i];
               o_rise[i] <= sync_reg[i];
               o_fall[i] <= ~sync_reg[i];
            end else begin
               cnt_reg[i] <= cnt_reg[i] + 32'h1;
            end
         end
      end
   end
endmodule

// file: logic/drive_run_control.sv
// Contract
// - two-wire: fwd alone forward, rev alone reverse, none stop, both hold
// - three-wire: self-hold only while stop input is on; starts are momentary
// - three-wire: start pulse latches run; other direction pulse reverses
// - three-wire: stop input off cancels latched run, ramps down
// - terminal codes 6 fwd, 7 rev, 9 stop; source must be terminals
// - source 2 takes run commands from serial host
// - stop lock 0 plus 2 s enter hold disables stop key; default 1
// - after stop key halts terminal run, contact must reopen then close (two-wire only; three-wire restarts on the next start contact opening)
// - reverse permit 0 forbids reverse and direction changes; default 1
// - output never above max frequency (code exceeds it for one cycle when max is lowered below the output); max up to 400.00, default 50.00
// - setpoint below min gives min; min default 0.00, not above max
// - accel and decel times span zero to max, 0.1 to 999.9 s
// - primary ramp times by default; alternates picked by terminal
// - voltage follows min, mid, base points; defaults 380, 15, 1.25
// - curve settings kept ordered (factory mid voltage 14.00 is below min voltage 15.00); max voltage at most 500.00
// - carrier setting integer 1 to 15, default per variant
// - restore value 8 returns all settings to factory values
// - write lock 1 refuses restore and changes
// - lock guards everything but setpoint and the lock itself; default unlocked
// - run source 0 panel, 1 terminals, 2 serial
module drive_run_control #(
   parameter int HOLD_CYCLES = drive_ctrl_pkg::HOLD_CYC,
   parameter int DEBOUNCE_CYCLES = drive_ctrl_pkg::DEBOUNCE_CYC,
   parameter int TICK_CYCLES = drive_ctrl_pkg::TICK_CYC,
   parameter logic [3:0] CARRIER_DEFAULT = drive_ctrl_pkg::RST_CARRIER
) (
   // clock and reset
   input wire logic i_core_clk,
   input wire logic i_rstn,
   // terminals a..c and panel keys (raw pins)
   input wire logic [2:0] i_term_pins,
   input wire logic i_alt_ramp_pin,
   input wire logic i_key_run,
   input wire logic i_key_stop,
   input wire logic i_key_enter,
   input wire logic i_key_dir,
   // serial host commands (core clock domain)
   input wire logic i_serial_run,
   input wire logic i_serial_rev,
   // parameter write port
   input wire logic i_param_we,
   input wire logic [4:0] i_param_id,
   input wire logic [15:0] i_param_data,
   // outputs
   output drive_ctrl_pkg::run_state_t o_run_state,
   output logic [15:0] o_freq_ref,
   output logic [15:0] o_volt_ref,
   output logic [3:0] o_carrier_select,
   output logic o_stop_key_disabled,
   output logic o_param_refused
);
   import drive_ctrl_pkg::*;

   // ------------------------------------------------------------
   // input conditioning
   // ------------------------------------------------------------
   logic [7:0] lvl, rise, fall;
   input_filter #(.WIDTH(8), .STABLE_CYC(DEBOUNCE_CYCLES)) u_filter (
      .i_core_clk(i_core_clk),
      .i_rstn(i_rstn),
      .i_raw({i_key_dir, i_key_enter, i_key_stop, i_key_run, i_alt_ramp_pin, i_term_pins}),
      .o_level(lvl),
      .o_rise(rise),
      .o_fall(fall)
   );

   // ------------------------------------------------------------
   // parameters
   // ------------------------------------------------------------
   logic [15:0] setpoint_reg, max_freq_reg, min_freq_reg;
   logic [15:0] accel_reg, decel_reg, accel2_reg, decel2_reg;
   logic [15:0] vf_maxv_reg, vf_basef_reg, vf_midv_reg, vf_midf_reg, vf_minv_reg, vf_minf_reg;
   logic [1:0] run_src_reg;
   logic stop_lock_reg, rev_permit_reg, wlock_reg;
   logic [4:0] term_fn_reg [3];
   logic [15:0] d;
   logic ok;

   always_comb begin
      d = i_param_data;
      ok = 1'b1;
      case (i_param_id)
         PID_SETPOINT: ok = d <= max_freq_reg;
         PID_RUN_SRC: ok = d <= 16'(SRC_SERIAL);
         PID_STOP_LOCK, PID_REV_PERMIT, PID_WLOCK: ok = d <= 16'h1;
         PID_MAX_FREQ: ok = d >= min_freq_reg && d <= FREQ_CEIL && d >= vf_basef_reg;
         PID_MIN_FREQ: ok = d <= max_freq_reg;
         PID_ACCEL, PID_DECEL, PID_ACCEL2, PID_DECEL2: ok = d >= TIME_MIN && d <= TIME_MAX;
         PID_VF_MAXV: ok = d > vf_midv_reg && d <= VOLT_CEIL;
         PID_VF_MIDV: ok = d >= vf_minv_reg && d < vf_maxv_reg;
         PID_VF_MINV: ok = d <= vf_midv_reg;
         PID_VF_BASEF: ok = d >= vf_midf_reg && d <= max_freq_reg;
         PID_VF_MIDF: ok = d >= vf_minf_reg && d <= vf_basef_reg;
         PID_VF_MINF: ok = d <= vf_midf_reg;
         PID_CARRIER: ok = d >= 16'(CARRIER_MIN) && d <= 16'(CARRIER_MAX);
         PID_RESTORE: ok = d <= 16'(RESTORE_CODE);
         PID_TERM_A, PID_TERM_B, PID_TERM_C: ok = d <= 16'h1f;
         default: ok = 1'b0;
      endcase
      if (wlock_reg && i_param_id != PID_SETPOINT && i_param_id != PID_WLOCK) begin
         ok = 1'b0;
      end
   end

   logic restore;
   assign restore = i_param_we && ok && i_param_id == PID_RESTORE
                    && d[3:0] == RESTORE_CODE;

   always_ff @(posedge i_core_clk or negedge i_rstn) begin
      if (!i_rstn || restore) begin
         setpoint_reg <= RST_SETPOINT;
         run_src_reg <= RST_RUN_SRC;
         stop_lock_reg <= RST_STOP_LOCK;
         rev_permit_reg <= RST_REV_PERMIT;
         max_freq_reg <= RST_MAX_FREQ;
         min_freq_reg <= RST_MIN_FREQ;
         accel_reg <= RST_ACCEL;
         decel_reg <= RST_DECEL;
         accel2_reg <= RST_ACCEL;
         decel2_reg <= RST_DECEL;
         vf_maxv_reg <= RST_VF_MAXV;
         vf_basef_reg <= RST_VF_BASEF;
         vf_midv_reg <= RST_VF_MIDV;
         vf_midf_reg <= RST_VF_MIDF;
         vf_minv_reg <= RST_VF_MINV;
         vf_minf_reg <= RST_VF_MINF;
         o_carrier_select <= CARRIER_DEFAULT;
         wlock_reg <= 1'b0;
         term_fn_reg[0] <= RST_TERM_A;
         term_fn_reg[1] <= RST_TERM_B;
         term_fn_reg[2] <= RST_TERM_C;
      end else if (i_param_we && ok) begin
         case (i_param_id)
            PID_SETPOINT: setpoint_reg <= d;
            PID_RUN_SRC: run_src_reg <= d[1:0];
            PID_STOP_LOCK: stop_lock_reg <= d[0];
            PID_REV_PERMIT: rev_permit_reg <= d[0];
            PID_MAX_FREQ: max_freq_reg <= d;
            PID_MIN_FREQ: min_freq_reg <= d;
            PID_ACCEL: accel_reg <= d;
            PID_DECEL: decel_reg <= d;
            PID_ACCEL2: accel2_reg <= d;
            PID_DECEL2: decel2_reg <= d;
            PID_VF_MAXV: vf_maxv_reg <= d;
            PID_VF_BASEF: vf_basef_reg <= d;
            PID_VF_MIDV: vf_midv_reg <= d;
            PID_VF_MIDF: vf_midf_reg <= d;
            PID_VF_MINV: vf_minv_reg <= d;
            PID_VF_MINF: vf_minf_reg <= d;
            PID_CARRIER: o_carrier_select <= d[3:0];
            PID_WLOCK: wlock_reg <= d[0];
            PID_TERM_A: term_fn_reg[0] <= d[4:0];
            PID_TERM_B: term_fn_reg[1] <= d[4:0];
            PID_TERM_C: term_fn_reg[2] <= d[4:0];
            default: ;
         endcase
      end
   end

   always_ff @(posedge i_core_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         o_param_refused <= 1'b0;
      end else begin
         o_param_refused <= i_param_we && !ok;
      end
   end

   // ------------------------------------------------------------
   // terminal function mapping
   // ------------------------------------------------------------
   function automatic logic [2:0] map_fn(input logic [2:0] v, input logic [4:0] fn [3]);
      logic [2:0] r;
      r = 3'h0;
      for (int i = 0; i < 3; i++) begin
         if (fn[i] == TERM_FN_FWD) r[0] = r[0] | v[i];
         if (fn[i] == TERM_FN_REV) r[1] = r[1] | v[i];
         if (fn[i] == TERM_FN_STOP) r[2] = r[2] | v[i];
      end
      return r;
   endfunction

   logic [2:0] t_lvl, t_fall;
   logic three_wire;
   always_comb begin
      t_lvl = map_fn(lvl[2:0], term_fn_reg);
      t_fall = map_fn(fall[2:0], term_fn_reg);
      three_wire = 1'b0;
      for (int i = 0; i < 3; i++) begin
         if (term_fn_reg[i] == TERM_FN_STOP) three_wire = 1'b1;
      end
   end

   // ------------------------------------------------------------
   // stop key lock: enter held for the hold time arms the lock
   // ------------------------------------------------------------
   logic [31:0] hold_cnt_reg;
   always_ff @(posedge i_core_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         hold_cnt_reg <= '0;
         o_stop_key_disabled <= 1'b0;
      end else begin
         if (!lvl[6]) begin
            hold_cnt_reg <= '0;
         end else if (hold_cnt_reg < 32'(HOLD_CYCLES)) begin
            hold_cnt_reg <= hold_cnt_reg + 32'h1;
         end
         if (restore) begin
            o_stop_key_disabled <= 1'b0;
         end else if (lvl[6] && hold_cnt_reg == 32'(HOLD_CYCLES - 1)) begin
            o_stop_key_disabled <= !stop_lock_reg;
         end
      end
   end

   logic stop_key;
   assign stop_key = rise[5] && !o_stop_key_disabled;

   // ------------------------------------------------------------
   // run command decoding
   // ------------------------------------------------------------
   run_state_t run_next;
   logic inhibit_reg;
   always_comb begin
      run_next = o_run_state;
      case (run_src_reg)
         SRC_PANEL: begin
            if (rise[4]) run_next = o_run_state == RUN_STOP ? RUN_FWD : o_run_state;
            if (rise[7] && o_run_state != RUN_STOP) begin
               run_next = o_run_state == RUN_FWD ? RUN_REV : RUN_FWD;
            end
         end
         SRC_TERM: begin
            if (three_wire) begin
               if (!t_lvl[2] || t_fall[2]) run_next = RUN_STOP;
               else if (t_fall[0]) run_next = RUN_FWD;
               else if (t_fall[1]) run_next = RUN_REV;
            end else if (inhibit_reg) begin
               run_next = RUN_STOP;
            end else begin
               case (t_lvl[1:0])
                  2'b01: run_next = RUN_FWD;
                  2'b10: run_next = RUN_REV;
                  2'b00: run_next = RUN_STOP;
                  default: run_next = o_run_state;
               endcase
            end
         end
         SRC_SERIAL: begin
            run_next = !i_serial_run ? RUN_STOP : (i_serial_rev ? RUN_REV : RUN_FWD);
         end
         default: run_next = RUN_STOP;
      endcase
      if (!rev_permit_reg) begin
         if (run_next == RUN_REV) run_next = o_run_state == RUN_FWD ? RUN_FWD : RUN_STOP;
      end
      if (stop_key) run_next = RUN_STOP;
   end

   always_ff @(posedge i_core_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         o_run_state <= RUN_STOP;
         inhibit_reg <= 1'b0;
      end else begin
         o_run_state <= run_next;
         if (stop_key && run_src_reg == SRC_TERM) inhibit_reg <= 1'b1;
         else if (t_lvl[1:0] == 2'b00) inhibit_reg <= 1'b0;
      end
   end

   // ------------------------------------------------------------
   // ramp generator
   // ------------------------------------------------------------
   logic [15:0] target, ramp_time, step_units, gap;
   logic [31:0] tick_cnt_reg, acc_reg, step_num, acc_sum, ramp_thr;
   logic tick;
   always_comb begin
      if (o_run_state == RUN_STOP) target = 16'h0;
      else if (setpoint_reg < min_freq_reg) target = min_freq_reg;
      else if (setpoint_reg > max_freq_reg) target = max_freq_reg;
      else target = setpoint_reg;
      if (target >= o_freq_ref) ramp_time = lvl[3] ? accel2_reg : accel_reg;
      else ramp_time = lvl[3] ? decel2_reg : decel_reg;
      step_num = 32'(max_freq_reg);
      acc_sum = acc_reg + step_num;
      ramp_thr = 32'(ramp_time) * TICKS_PER_DS;
      step_units = 16'(acc_sum / ramp_thr);
      gap = target > o_freq_ref ? target - o_freq_ref : o_freq_ref - target;
   end
   assign tick = tick_cnt_reg == 32'(TICK_CYCLES - 1);

   always_ff @(posedge i_core_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         tick_cnt_reg <= '0;
      end else begin
         tick_cnt_reg <= tick ? 32'h0 : tick_cnt_reg + 32'h1;
      end
   end

   // fractional accumulator: max_freq per ramp_time*TICKS_PER_DS ticks
   always_ff @(posedge i_core_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         acc_reg <= '0;
         o_freq_ref <= '0;
      end else if (o_freq_ref > max_freq_reg) begin
         o_freq_ref <= max_freq_reg;
         acc_reg <= '0;
      end else if (tick) begin
         if (o_freq_ref == target) begin
            acc_reg <= '0;
         end else begin
            acc_reg <= acc_sum % ramp_thr;
            if (step_units >= gap) o_freq_ref <= target;
            else if (target > o_freq_ref) o_freq_ref <= o_freq_ref + step_units;
            else o_freq_ref <= o_freq_ref - step_units;
         end
      end
   end

   // ------------------------------------------------------------
   // v/f curve
   // ------------------------------------------------------------
   function automatic logic [15:0] interp(input logic [15:0] f, input logic [15:0] f0,
                                          input logic [15:0] f1, input logic [15:0] v0,
                                          input logic [15:0] v1);
      logic [31:0] num;
      logic [15:0] dv;
      dv = v1 >= v0 ? v1 - v0 : v0 - v1;
      num = 32'(f - f0) * 32'(dv);
      if (f1 <= f0) return v1;
      if (v1 < v0) return v0 - 16'(num / 32'(f1 - f0));
      return v0 + 16'(num / 32'(f1 - f0));
   endfunction

   always_ff @(posedge i_core_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         o_volt_ref <= '0;
      end else if (o_freq_ref < vf_minf_reg) begin
         o_volt_ref <= interp(o_freq_ref, 16'h0, vf_minf_reg, 16'h0, vf_minv_reg);
      end else if (o_freq_ref < vf_midf_reg) begin
         o_volt_ref <= interp(o_freq_ref, vf_minf_reg, vf_midf_reg, vf_minv_reg, vf_midv_reg);
      end else if (o_freq_ref < vf_basef_reg) begin
         o_volt_ref <= interp(o_freq_ref, vf_midf_reg, vf_basef_reg, vf_midv_reg, vf_maxv_reg);
      end else begin
         o_volt_ref <= vf_maxv_reg;
      end
   end

   // ------------------------------------------------------------
   // checks
   // ------------------------------------------------------------
   a_freq_max_bound: assert property (@(posedge i_core_clk) disable iff (!i_rstn)
      $past(o_freq_ref) <= max_freq_reg |-> o_freq_ref <= max_freq_reg)
      else $error("frequency above max");
   a_lock_refuses: assert property (@(posedge i_core_clk) disable iff (!i_rstn)
      wlock_reg && i_param_we && i_param_id == PID_MAX_FREQ |=> o_param_refused)
      else $error("locked write accepted");
   a_serial_run: assert property (@(posedge i_core_clk) disable iff (!i_rstn)
      run_src_reg == SRC_SERIAL && !i_serial_run && !stop_key |=> o_run_state == RUN_STOP)
      else $error("serial stop ignored");
   a_no_reverse: assert property (@(posedge i_core_clk) disable iff (!i_rstn)
      !rev_permit_reg && o_run_state != RUN_REV |=> o_run_state != RUN_REV)
      else $error("reverse while prohibited");
   a_two_wire_stop: assert property (@(posedge i_core_clk) disable iff (!i_rstn)
      run_src_reg == SRC_TERM && !three_wire && t_lvl[1:0] == 2'b00 |=> o_run_state == RUN_STOP)
      else $error("two-wire stop missed");
   a_stop_cancel: assert property (@(posedge i_core_clk) disable iff (!i_rstn)
      run_src_reg == SRC_TERM && three_wire && !t_lvl[2] |=> o_run_state == RUN_STOP)
      else $error("three-wire stop missed");
   a_carrier_range: assert property (@(posedge i_core_clk) disable iff (!i_rstn)
      o_carrier_select >= CARRIER_MIN)
      else $error("carrier out of range");
   a_restore_max: assert property (@(posedge i_core_clk) disable iff (!i_rstn)
      restore |=> max_freq_reg == RST_MAX_FREQ && !wlock_reg)
      else $error("restore incomplete");
endmodule

// file: verif/operator_side.sv
module operator_side (
   // clock
   input wire logic i_core_clk,
   // wanted contact and key levels
   input wire logic [6:0] i_want,
   // pins with one bounce cycle
   output logic [6:0] o_pins
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [6:0] s1_reg = 7'h00;
   logic [6:0] s2_reg = 7'h00;
   logic [6:0] s3_reg = 7'h00;
   // each change shows new, old, new before settling
   always_ff @(negedge i_core_clk) begin
      s1_reg <= i_want;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
   end
   assign o_pins = s1_reg ^ s2_reg ^ s3_reg;
endmodule

// file: verif/tb.sv
module tb;
   timeunit 1ns;
   timeprecision 1ps;
   import drive_ctrl_pkg::*;
   logic clk = 1'b0;
   logic rstn = 1'b0;
   logic [6:0] want = 7'h00;
   logic [6:0] pins;
   logic alt = 1'b0, srun = 1'b0, srev = 1'b0, we = 1'b0, rf;
   logic [4:0] pid = 5'h00;
   logic [15:0] pdat = 16'h0000, fref, vref;
   logic [3:0] car;
   logic skd, refu;
   run_state_t rs;
   int num_errors = 0, total_checks = 0, cyc = 0;
   always #5 clk = ~clk;
   operator_side op (.i_core_clk(clk), .i_want(want), .o_pins(pins));
   drive_run_control #(.HOLD_CYCLES(20), .DEBOUNCE_CYCLES(3), .TICK_CYCLES(2)) dut (
      .i_core_clk(clk), .i_rstn(rstn), .i_term_pins(pins[2:0]), .i_alt_ramp_pin(alt),
      .i_key_run(pins[3]), .i_key_stop(pins[4]), .i_key_enter(pins[5]),
      .i_key_dir(pins[6]), .i_serial_run(srun), .i_serial_rev(srev),
      .i_param_we(we), .i_param_id(pid), .i_param_data(pdat), .o_run_state(rs),
      .o_freq_ref(fref), .o_volt_ref(vref), .o_carrier_select(car),
      .o_stop_key_disabled(skd), .o_param_refused(refu));
   task automatic print_verdict();
      $display("checks %0d errors %0d", total_checks, num_errors);
      if (num_errors == 0 && total_checks > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cyc == 30000) begin
         num_errors++;
         print_verdict();
      end
   end
   task automatic tk(int n);
      repeat (n) @(negedge clk);
   endtask
   task automatic chk(logic [15:0] got, logic [15:0] exp);
      total_checks++;
      if (got !== exp) begin
         num_errors++;
         $display("unexpected at %0t got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic st(run_state_t exp);
      chk({13'h0000, rs}, {13'h0000, exp});
   endtask
   task automatic wp(logic [4:0] id, logic [15:0] d, logic exp);
      @(negedge clk);
      we = 1'b1;
      pid = id;
      pdat = d;
      @(negedge clk);
      we = 1'b0;
      rf = refu;
      @(negedge clk);
      rf = rf | refu;
      chk({15'h0000, rf}, {15'h0000, exp});
   endtask
   task automatic pin(logic [6:0] w);
      want <= w;
      tk(14);
   endtask
   task automatic two_wire();
      wp(PID_RUN_SRC, 16'h0001, 1'b0);
      wp(PID_TERM_C, 16'h0000, 1'b0);
      pin(7'h01); st(RUN_FWD);
      pin(7'h03); st(RUN_FWD);
      pin(7'h02); st(RUN_REV);
      pin(7'h00); st(RUN_STOP);
      pin(7'h01); pin(7'h11); st(RUN_STOP);
      pin(7'h01); st(RUN_STOP);
      pin(7'h00); pin(7'h01); st(RUN_FWD);
      wp(PID_STOP_LOCK, 16'h0000, 1'b0);
      want <= 7'h21;
      tk(40);
      chk({15'h0000, skd}, 16'h0001);
      pin(7'h11); st(RUN_FWD);
   endtask
   task automatic three_wire();
      wp(PID_RESTORE, 16'h0008, 1'b0);
      chk({12'h000, car}, 16'h0005);
      chk({15'h0000, skd}, 16'h0000);
      pin(7'h00);
      pin(7'h10);
      st(RUN_STOP);
      wp(PID_RUN_SRC, 16'h0001, 1'b0);
      pin(7'h04); pin(7'h05); pin(7'h04); st(RUN_FWD);
      pin(7'h06); pin(7'h04); st(RUN_REV);
      pin(7'h00); st(RUN_STOP);
      pin(7'h01); pin(7'h00); st(RUN_STOP);
   endtask
   task automatic serial_dir();
      wp(PID_RUN_SRC, 16'h0002, 1'b0);
      srun = 1'b1; tk(3); st(RUN_FWD);
      wp(PID_REV_PERMIT, 16'h0000, 1'b0);
      srev = 1'b1; tk(3); st(RUN_FWD);
      wp(PID_REV_PERMIT, 16'h0001, 1'b0);
      tk(3); st(RUN_REV);
      srun = 1'b0; tk(3); st(RUN_STOP);
   endtask
   task automatic limits();
      wp(PID_RUN_SRC, 16'h0000, 1'b0);
      wp(PID_ACCEL, 16'h0001, 1'b0);
      wp(PID_DECEL, 16'h0001, 1'b0);
      wp(PID_ACCEL, 16'h0000, 1'b1);
      wp(PID_SETPOINT, RST_MAX_FREQ, 1'b0);
      pin(7'h08); pin(7'h00); st(RUN_FWD);
      tk(1000);
      chk({15'h0000, fref > 16'h07d0 && fref < 16'h0bb8}, 16'h0001);
      tk(1500);
      chk(fref, RST_MAX_FREQ);
      chk(vref, RST_VF_MAXV);
      wp(PID_MIN_FREQ, 16'h03e8, 1'b0);
      wp(PID_SETPOINT, 16'h01f4, 1'b0);
      tk(2500);
      chk(fref, 16'h03e8);
      chk(vref, 16'h1c0a);
      alt = 1'b1;
      tk(10);
      wp(PID_SETPOINT, RST_MAX_FREQ, 1'b0);
      tk(320);
      chk({15'h0000, fref > 16'h03e8 && fref < 16'h0400}, 16'h0001);
      alt = 1'b0;
      wp(PID_CARRIER, 16'h0000, 1'b1);
      wp(PID_CARRIER, 16'h000f, 1'b0);
      chk({12'h000, car}, 16'h000f);
      pin(7'h40);
      pin(7'h00);
      st(RUN_REV);
   endtask
   task automatic wlock();
      wp(PID_WLOCK, 16'h0001, 1'b0);
      wp(PID_MAX_FREQ, 16'h1770, 1'b1);
      wp(PID_SETPOINT, 16'h04b0, 1'b0);
      tk(100);
      chk(fref, 16'h04b0);
      wp(PID_RESTORE, 16'h0008, 1'b1);
      chk({12'h000, car}, 16'h000f);
      wp(PID_WLOCK, 16'h0000, 1'b0);
      wp(PID_CARRIER, 16'h0003, 1'b0);
      chk({12'h000, car}, 16'h0003);
   endtask
   initial begin
      tk(9);
      rstn = 1'b1;
      tk(1);
      st(RUN_STOP);
      chk({12'h000, car}, 16'h0005);
      chk(fref, 16'h0000);
      two_wire();
      three_wire();
      serial_dir();
      limits();
      wlock();
      print_verdict();
   end
endmodule
